/* File: common/ladder_dac_pkg.sv */
// Package with register map, field positions and control encodings of the ladder converter.
`default_nettype none
package ladder_dac_pkg;
  // Register byte addresses on the AHB-Lite bus.
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] LEVEL_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;
  localparam int         ADDR_BITS      = 8;

  // Field positions in the control register.
  localparam int ENABLE_BIT     = 7;
  localparam int LOW_POWER_BIT  = 6;
  localparam int PIN_DRIVE_BIT  = 5;
  localparam int POS_SEL_HI     = 3;
  localparam int POS_SEL_LO     = 2;
  localparam int NEG_SEL_BIT    = 0;

  // Writable masks; unimplemented bits read as zero.
  localparam logic [7:0] CONTROL_MASK = 8'hED;
  localparam logic [7:0] LEVEL_MASK   = 8'h1F;

  // Values after reset.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET   = 8'h00;

  // Level code properties.
  localparam int         LEVEL_BITS = 5;
  localparam logic [4:0] LEVEL_ALL_ONES = 5'h1F;
  localparam logic [4:0] LEVEL_ALL_ZERO = 5'h00;

  // Positive source encodings.
  typedef enum logic [1:0] {
    POS_SUPPLY   = 2'b00,
    POS_EXT_PIN  = 2'b01,
    POS_FIXED    = 2'b10,
    POS_RESERVED = 2'b11
  } pos_source_t;

  // Operating modes of the ladder as seen by the analog section.
  typedef enum logic [1:0] {
    MODE_OFF        = 2'b00,
    MODE_RATIO      = 2'b01,
    MODE_CLAMP_HIGH = 2'b10,
    MODE_CLAMP_LOW  = 2'b11
  } ladder_mode_t;

  // AHB transfer type and size codes used by the slave.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
endpackage : ladder_dac_pkg
`default_nettype wire

/* File: hdl/ladder_ahb_slave.sv */
// AHB-Lite slave front end that turns bus transfers into register write and read strobes.
`default_nettype none
module ladder_ahb_slave
  import ladder_dac_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // AHB-Lite slave side.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  // Register side.
  output logic                      writeStrobe,
  output logic                      readStrobe,
  output logic [ADDR_BITS-1:0]      regAddr
);

  typedef struct packed {
    logic                 wrPend;
    logic [ADDR_BITS-1:0] addr;
  } slave_state_t;

  slave_state_t state_reg;
  slave_state_t state_next;
  logic         takeAccess;

  // A transfer is accepted on a valid address phase; only whole words are honoured.
  assign takeAccess = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  // Capture the address phase so the write lands in the data phase.
  always_comb begin
    state_next        = state_reg;
    state_next.wrPend = takeAccess && hwrite;
    if (takeAccess) begin
      state_next.addr = haddr[ADDR_BITS-1:0];
    end
  end

  // State register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reads are decoded from the live address phase, writes from the held one.
  assign writeStrobe = state_reg.wrPend;
  assign readStrobe  = takeAccess && !hwrite;
  assign regAddr     = writeStrobe ? state_reg.addr : haddr[ADDR_BITS-1:0];

endmodule : ladder_ahb_slave
`default_nettype wire

/* File: hdl/ladder_pin_mux.sv */
// Reference pin multiplexer that hands the pin to the analog ladder or the digital port.
`default_nettype none
module ladder_pin_mux (
  // Override control.
  input  wire logic analogOverride,
  // Digital port side.
  input  wire logic portOut,
  input  wire logic portOutEnable,
  output logic      portIn,
  // Pin side.
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOutEnable,
  output logic      pinInputEnable
);

  // The analog route removes the output driver and the input detector; reads give zero.
  always_comb begin
    pinOut         = analogOverride ? 1'b0 : portOut;
    pinOutEnable   = analogOverride ? 1'b0 : portOutEnable;
    pinInputEnable = !analogOverride;
    portIn         = analogOverride ? 1'b0 : pinIn;
  end

endmodule : ladder_pin_mux
`default_nettype wire

/* File: hdl/ladder_dac_control.sv */
// Control logic of the 32-level ladder reference with its AHB-Lite register file.
//
// Behaviour
// [R1] Enable bit 7 of control register turns the converter on; clear keeps off.
// [R2] Thirty-two levels chosen by a five-bit level code in level register.
// [R3] Enabled output is low source plus difference times code over 32.
// [R4] Disabled, low-power set, code all ones: output clamps to high source.
// [R5] Disabled, low-power clear, code all zeros: output clamps to low source.
// [R6] Low-power set opens the low source; clear opens the high source.
// [R7] Pin drive bit routes the voltage to the pin, overriding digital buffers.
// [R8] A digital read of the pin returns zero while carrying the voltage.
// [R9] Positive select: 00 supply, 01 external pin, 10 fixed reference, 11 reserved.
// [R10] Negative select one picks external low reference, zero picks ground.
// [R11] Waking from sleep leaves the control register untouched.
// [R12] Any reset disables, removes pin voltage and clears the level code.
// [R13] Unimplemented bits of both registers read as zero.
// [R14] Software should disable the reference before sleep to save current.
// [R15] Writes act on the next clock edge and drive registered analog controls.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`default_nettype none
module ladder_dac_control
  import ladder_dac_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state.
  input  wire logic        sleeping,
  // Analog ladder controls.
  output logic             ladderEnable,
  output logic [4:0]       levelCode,
  output logic             highSourceConnect,
  output logic             lowSourceConnect,
  output logic [1:0]       positiveSourceSelect,
  output logic             negativeSourceSelect,
  output logic [1:0]       ladderMode,
  output logic             pinAnalogRoute,
  // Reference pin and its digital port.
  input  wire logic        portOut,
  input  wire logic        portOutEnable,
  output logic             portIn,
  input  wire logic        refPinIn,
  output logic             refPinOut,
  output logic             refPinOutEnable,
  output logic             refPinInputEnable
);

  typedef struct packed {
    logic [7:0]   control;
    logic [7:0]   level;
    logic         enable;
    logic [4:0]   code;
    logic         highConn;
    logic         lowConn;
    logic [1:0]   posSel;
    logic         negSel;
    ladder_mode_t mode;
    logic         pinRoute;
    logic [31:0]  rdata;
  } ctrl_state_t;

  ctrl_state_t          state_reg;
  ctrl_state_t          state_next;
  logic                 writeStrobe;
  logic                 readStrobe;
  logic [ADDR_BITS-1:0] regAddr;
  logic [7:0]           statusWord;

  // Bus front end.
  ladder_ahb_slave busSlave (
    .clock       (clock),
    .resetn      (resetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hready      (hready),
    .writeStrobe (writeStrobe),
    .readStrobe  (readStrobe),
    .regAddr     (regAddr)
  );

  // Status view of the sleep input and of the ladder state as driven to the analog section.
  assign statusWord = {state_reg.enable, state_reg.pinRoute, state_reg.mode,
                       state_reg.highConn, state_reg.lowConn, 1'b0, sleeping};

  // Register writes, read data capture and derived analog controls.
  always_comb begin
    state_next = state_reg;
    // Writes take effect at the next edge; sleep has no path into the control or level registers.
    if (writeStrobe) begin  // [R11]
      case (regAddr)
        CONTROL_OFFSET: state_next.control = hwdata[7:0] & CONTROL_MASK;  // [R13] [R15]
        LEVEL_OFFSET:   state_next.level   = hwdata[7:0] & LEVEL_MASK;    // [R2] [R13]
        default:        state_next.control = state_next.control;
      endcase
    end
    // Read data are latched in the address phase and shown in the data phase; the read
    // decodes the live address, since regAddr points at a write still in its data phase.
    if (readStrobe) begin
      case (haddr[ADDR_BITS-1:0])
        CONTROL_OFFSET: state_next.rdata = {24'h000000, state_reg.control};  // [R13]
        LEVEL_OFFSET:   state_next.rdata = {24'h000000, state_reg.level};    // [R13]
        STATUS_OFFSET:  state_next.rdata = {24'h000000, statusWord};
        default:        state_next.rdata = 32'h00000000;
      endcase
    end
    // Registered analog controls follow the register contents on the same edge.
    state_next.enable   = state_next.control[ENABLE_BIT];                   // [R1] [R15]
    state_next.code     = state_next.level[LEVEL_BITS-1:0];                 // [R2] [R3]
    state_next.posSel   = state_next.control[POS_SEL_HI:POS_SEL_LO];        // [R9]
    state_next.negSel   = state_next.control[NEG_SEL_BIT];                  // [R10]
    state_next.pinRoute = state_next.control[PIN_DRIVE_BIT];                // [R7]
    // Reserved positive code leaves the high end open.
    if (state_next.enable) begin
      state_next.highConn = (state_next.posSel != POS_RESERVED);            // [R3] [R9]
      state_next.lowConn  = 1'b1;                                           // [R3]
      state_next.mode     = MODE_RATIO;                                     // [R3]
    end else begin
      state_next.highConn = state_next.control[LOW_POWER_BIT]
                            && (state_next.posSel != POS_RESERVED);         // [R6]
      state_next.lowConn  = !state_next.control[LOW_POWER_BIT];             // [R6]
      if (state_next.control[LOW_POWER_BIT] && state_next.code == LEVEL_ALL_ONES) begin
        state_next.mode = MODE_CLAMP_HIGH;                                  // [R4]
      end else if (!state_next.control[LOW_POWER_BIT]
                   && state_next.code == LEVEL_ALL_ZERO) begin
        state_next.mode = MODE_CLAMP_LOW;                                   // [R5]
      end else begin
        state_next.mode = MODE_OFF;
      end
    end
  end

  // State register; reset clears enable, pin route and level code.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg         <= '0;                                              // [R12]
      state_reg.control <= CONTROL_RESET;                                   // [R12]
      state_reg.level   <= LEVEL_RESET;                                     // [R12]
      state_reg.mode    <= MODE_CLAMP_LOW;
      state_reg.lowConn <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin multiplexer for the reference pin.
  ladder_pin_mux pinMux (
    .analogOverride (state_reg.pinRoute),
    .portOut        (portOut),
    .portOutEnable  (portOutEnable),
    .portIn         (portIn),
    .pinIn          (refPinIn),
    .pinOut         (refPinOut),
    .pinOutEnable   (refPinOutEnable),
    .pinInputEnable (refPinInputEnable)
  );  // [R7] [R8]

  // Bus answers: zero wait states and always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_reg.rdata;

  // Analog section outputs, all registered.
  assign ladderEnable         = state_reg.enable;
  assign levelCode            = state_reg.code;
  assign highSourceConnect    = state_reg.highConn;
  assign lowSourceConnect     = state_reg.lowConn;
  assign positiveSourceSelect = state_reg.posSel;
  assign negativeSourceSelect = state_reg.negSel;
  assign ladderMode           = state_reg.mode;
  assign pinAnalogRoute       = state_reg.pinRoute;

endmodule : ladder_dac_control
`default_nettype wire

/* File: sim/ladder_dac_chk.sv */
// Checker of the ladder converter control seen at its ports.
`default_nettype none
module ladder_dac_chk
  import ladder_dac_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Ladder and pin controls.
  input wire logic        ladderEnable,
  input wire logic [4:0]  levelCode,
  input wire logic        highSourceConnect,
  input wire logic        lowSourceConnect,
  input wire logic [1:0]  positiveSourceSelect,
  input wire logic        negativeSourceSelect,
  input wire logic [1:0]  ladderMode,
  input wire logic        pinAnalogRoute,
  input wire logic        portIn,
  input wire logic        refPinOutEnable,
  input wire logic        refPinInputEnable
);
  logic take;
  logic ctlWr_reg;
  logic lvlWr_reg;
  // A taken word write; its data phase follows one cycle later.
  assign take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD && hwrite;
  // Marks the data phase of writes to each register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctlWr_reg <= 1'b0;
      lvlWr_reg <= 1'b0;
    end else begin
      ctlWr_reg <= take && haddr[7:0] == CONTROL_OFFSET;
      lvlWr_reg <= take && haddr[7:0] == LEVEL_OFFSET;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  enable_write_a: assert property (ctlWr_reg |=> ladderEnable == $past(hwdata[7]))
    else $error("enable bit not applied");
  level_write_a: assert property (lvlWr_reg |=> levelCode == $past(hwdata[4:0]))
    else $error("level code not applied");
  ratio_mode_a: assert property (ladderEnable |-> ladderMode == MODE_RATIO)
    else $error("enabled ladder not in ratio mode");
  clamp_high_a: assert property (!ladderEnable && levelCode == LEVEL_ALL_ONES
    && highSourceConnect && !lowSourceConnect |-> ladderMode == MODE_CLAMP_HIGH)
    else $error("high clamp mode missing");
  clamp_low_a: assert property (!ladderEnable && levelCode == LEVEL_ALL_ZERO
    && lowSourceConnect && !highSourceConnect |-> ladderMode == MODE_CLAMP_LOW)
    else $error("low clamp mode missing");
  low_power_a: assert property (ctlWr_reg && !hwdata[7]
    |=> lowSourceConnect == !$past(hwdata[6])) else $error("low side connection wrong");
  source_sel_a: assert property (ctlWr_reg
    |=> positiveSourceSelect == $past(hwdata[3:2]) && negativeSourceSelect == $past(hwdata[0]))
    else $error("source select wrong");
  pin_route_a: assert property (pinAnalogRoute |-> !refPinOutEnable && !refPinInputEnable
    && !portIn) else $error("routed pin still digital");
  control_hold_a: assert property (!ctlWr_reg |=> $stable(ladderEnable)
    && $stable(pinAnalogRoute) && $stable(positiveSourceSelect)) else $error("control drifted");
  reset_clear_a: assert property ($rose(resetn) |-> !ladderEnable && levelCode == 5'h00
    && !pinAnalogRoute) else $error("reset left converter active");
endmodule // ladder_dac_chk
`default_nettype wire

/* File: sim/ladder_dac_control_test.sv */
// Self-checking bench of the ladder converter control block.
`default_nettype none
module ladder_dac_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ladder_dac_pkg::*;
  logic clock = 0, resetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, sleeping = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, positiveSourceSelect, ladderMode;
  logic [2:0] hsize = HSIZE_WORD;
  logic [4:0] levelCode;
  logic ladderEnable, highSourceConnect, lowSourceConnect, negativeSourceSelect, pinAnalogRoute;
  logic portOut = 0, portOutEnable = 0, portIn, refPinIn = 0, refPinOut;
  logic refPinOutEnable, refPinInputEnable;
  int errCount = 0, nCompared = 0;
  // The single slave's ready closes the bus loop.
  assign hready = hreadyout;
  // Clock of 5 ns period.
  always #2.5 clock = ~clock;
  ladder_dac_control u_ladder_dac_control (
    .clock                (clock),
    .resetn               (resetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .sleeping             (sleeping),
    .ladderEnable         (ladderEnable),
    .levelCode            (levelCode),
    .highSourceConnect    (highSourceConnect),
    .lowSourceConnect     (lowSourceConnect),
    .positiveSourceSelect (positiveSourceSelect),
    .negativeSourceSelect (negativeSourceSelect),
    .ladderMode           (ladderMode),
    .pinAnalogRoute       (pinAnalogRoute),
    .portOut              (portOut),
    .portOutEnable        (portOutEnable),
    .portIn               (portIn),
    .refPinIn             (refPinIn),
    .refPinOut            (refPinOut),
    .refPinOutEnable      (refPinOutEnable),
    .refPinInputEnable    (refPinInputEnable)
  );
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // One single word transfer; read data lands in rd.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Values after the first reset.
  task automatic t_reset;
    xfer(1'b0, CONTROL_OFFSET, 0);
    chk(rd, 32'h00);
    chk(32'(hresp), 32'h0);
    xfer(1'b0, LEVEL_OFFSET, 0);
    chk(rd, 32'h00);
    xfer(1'b0, STATUS_OFFSET, 0);
    chk(rd, 32'h34);
  endtask
  // Writes of all ones, unmapped place included.
  task automatic t_masks;
    xfer(1'b1, CONTROL_OFFSET, 32'hFF);
    xfer(1'b1, LEVEL_OFFSET, 32'hFF);
    xfer(1'b1, 8'h0C, 32'hFF);
    #1 chk(32'(ladderMode), 32'(MODE_RATIO));
    chk(32'(levelCode), 32'h1F);
    chk(32'(ladderEnable), 32'h1);
    xfer(1'b0, CONTROL_OFFSET, 0);
    chk(rd, 32'hED);
    xfer(1'b0, LEVEL_OFFSET, 0);
    chk(rd, 32'h1F);
    xfer(1'b0, 8'h0C, 0);
    chk(rd, 32'h00);
    // A byte-sized write is not taken and leaves the level code alone.
    hsize <= 3'b000;
    xfer(1'b1, LEVEL_OFFSET, 32'h05);
    hsize <= HSIZE_WORD;
    xfer(1'b0, LEVEL_OFFSET, 0);
    chk(rd, 32'h1F);
  endtask
  // High clamp over positive select codes 00 to 10, with the reserved code checked only for both sides open; low clamp over both negative select codes.
  task automatic t_clamps;
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, CONTROL_OFFSET, 32'h40 | 32'(p << 2));
      #1 chk(32'(positiveSourceSelect), 32'(p));
      chk(32'({highSourceConnect, lowSourceConnect}), (p == 3) ? 32'h0 : 32'h2);
      if (p < 3) chk(32'(ladderMode), 32'(MODE_CLAMP_HIGH));
    end
    // Low-power side still set but the code is no longer all ones, so no clamp.
    xfer(1'b1, LEVEL_OFFSET, 0);
    #1 chk(32'(ladderMode), 32'(MODE_OFF));
    for (int n = 0; n < 2; n++) begin
      xfer(1'b1, CONTROL_OFFSET, 32'(n));
      #1 chk(32'(negativeSourceSelect), 32'(n));
      chk(32'(ladderMode), 32'(MODE_CLAMP_LOW));
    end
  endtask
  // Pin handed from the digital port to the ladder.
  task automatic t_pin;
    @(posedge clock);
    portOut <= 1'b1;
    portOutEnable <= 1'b1;
    refPinIn <= 1'b1;
    @(posedge clock);
    #1 chk(32'({refPinOut, refPinOutEnable, refPinInputEnable, portIn}), 32'hF);
    xfer(1'b1, CONTROL_OFFSET, 32'h20);
    #1 chk(32'({pinAnalogRoute, refPinOut, refPinOutEnable, refPinInputEnable}), 32'h8);
    chk(32'(portIn), 32'h0);
  endtask
  // Sleep keeps the control word; a reset in mid-run clears it.
  task automatic t_sleep;
    xfer(1'b1, LEVEL_OFFSET, 32'h11);
    // The converter is switched off before sleep to keep the current low.
    xfer(1'b1, CONTROL_OFFSET, 32'h25);
    sleeping <= 1'b1;
    repeat (5) @(posedge clock);
    xfer(1'b0, STATUS_OFFSET, 0);
    chk(rd & 32'hC1, 32'h41);
    sleeping <= 1'b0;
    xfer(1'b0, CONTROL_OFFSET, 0);
    chk(rd, 32'h25);
    // Enable again so that the reset has something to clear.
    xfer(1'b1, CONTROL_OFFSET, 32'hA5);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    #1 chk(32'({ladderEnable, levelCode, pinAnalogRoute}), 32'h0);
    @(posedge clock);
    resetn <= 1'b1;
    xfer(1'b0, LEVEL_OFFSET, 0);
    chk(rd, 32'h00);
    xfer(1'b0, CONTROL_OFFSET, 0);
    chk(rd, 32'h00);
  endtask
  // Prints the verdict and stops.
  task automatic closeOut;
    if (errCount == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_masks;
    t_clamps;
    t_pin;
    t_sleep;
    closeOut;
  end
  // Watchdog against a hung bus; the tests need about 90 cycles, the limit allows 1000.
  initial begin
    #5000;
    errCount++;
    closeOut;
  end
endmodule // ladder_dac_control_test
bind ladder_dac_control ladder_dac_chk u_ladder_dac_chk (
  .clock                (clock),
  .resetn               (resetn),
  .hsel                 (hsel),
  .haddr                (haddr),
  .htrans               (htrans),
  .hwrite               (hwrite),
  .hsize                (hsize),
  .hwdata               (hwdata),
  .hready               (hready),
  .ladderEnable         (ladderEnable),
  .levelCode            (levelCode),
  .highSourceConnect    (highSourceConnect),
  .lowSourceConnect     (lowSourceConnect),
  .positiveSourceSelect (positiveSourceSelect),
  .negativeSourceSelect (negativeSourceSelect),
  .ladderMode           (ladderMode),
  .pinAnalogRoute       (pinAnalogRoute),
  .portIn               (portIn),
  .refPinOutEnable      (refPinOutEnable),
  .refPinInputEnable    (refPinInputEnable)
);
`default_nettype wire
